// [rtl/ledfb_ctrl.sv]
// Purpose: frame bank and brightness control of a 48-channel LED sink driver
// Assumes: grayscale clock and open-LED sense arrive asynchronously
// Notes: sink outputs are PWM enables; analog current set by codes and gain
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module ledfb_ctrl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // pins from the panel
    input wire logic grayscale_clock_i,
    input wire logic [ledfb_pkg::CHANNELS-1:0] open_led_sense_i,
    // outputs to the analog side
    output logic [ledfb_pkg::CHANNELS-1:0] sink_output_channel_o,
    output logic [ledfb_pkg::CHANNELS-1:0] open_led_flag_o,
    output logic [ledfb_pkg::BC_W-1:0] global_brightness_code_o,
    output logic [ledfb_pkg::CC_W-1:0] red_group_brightness_o,
    output logic [ledfb_pkg::CC_W-1:0] green_group_brightness_o,
    output logic [ledfb_pkg::CC_W-1:0] blue_group_brightness_o,
    output logic [10:0] current_gain_x10_o,
    output logic [ledfb_pkg::LINE_W-1:0] scan_line_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [ledfb_pkg::BC_W-1:0] bc;
        logic [ledfb_pkg::CC_W-1:0] red_group_brightness;
        logic [ledfb_pkg::CC_W-1:0] green_group_brightness;
        logic [ledfb_pkg::CC_W-1:0] ccb;
        logic [29:0] fc1_stage;
        logic [5:0] fc2_stage;
        logic seg513;
        logic [ledfb_pkg::LINE_W-1:0] lines_m1;
        logic [ledfb_pkg::LINE_W-1:0] gs_line;
        logic [ledfb_pkg::CH_W-1:0] gs_ch;
        logic disp_bank;
        logic shown;
        logic grayscale_clock_s1;
        logic grayscale_clock_s2;
        logic grayscale_clock_s3;
        logic [ledfb_pkg::CHANNELS-1:0] sense_s1;
        logic [ledfb_pkg::CHANNELS-1:0] sense_s2;
        logic [ledfb_pkg::SEG_W-1:0] seg_cnt;
        logic [ledfb_pkg::LINE_W-1:0] line;
        logic [ledfb_pkg::CHANNELS-1:0] sink;
        logic [ledfb_pkg::CHANNELS-1:0] open_led_flag;
        logic [1:0][ledfb_pkg::LINES-1:0][ledfb_pkg::CHANNELS-1:0][ledfb_pkg::GS_W-1:0] mem;
    } ledfb_state_t;

    ledfb_state_t s_q;
    ledfb_state_t s_d;

    logic [31:0] rd_mux;
    logic [ledfb_pkg::GS_W-1:0] gs_word;
    logic grayscale_clock_rise;
    logic seg_end;

    assign grayscale_clock_rise = s_q.grayscale_clock_s2 & ~s_q.grayscale_clock_s3;
    assign seg_end = (s_q.seg_cnt ==
                      (s_q.seg513 ? ledfb_pkg::SEG_LONG_LAST : ledfb_pkg::SEG_SHORT_LAST));

    // read data selection, sampled in the first cycle of a read
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            ledfb_pkg::OFS_FC1: begin
                rd_mux[ledfb_pkg::FC1_BC_LSB +: ledfb_pkg::BC_W] = s_q.bc;
                rd_mux[ledfb_pkg::FC1_CCR_LSB +: ledfb_pkg::CC_W] = s_q.red_group_brightness;
                rd_mux[ledfb_pkg::FC1_CCG_LSB +: ledfb_pkg::CC_W] = s_q.green_group_brightness;
                rd_mux[ledfb_pkg::FC1_CCB_LSB +: ledfb_pkg::CC_W] = s_q.ccb;
            end
            ledfb_pkg::OFS_FC2: begin
                rd_mux[ledfb_pkg::FC2_SEG513_BIT] = s_q.seg513;
                rd_mux[ledfb_pkg::FC2_LINES_LSB +: ledfb_pkg::LINE_W] = s_q.lines_m1;
            end
            ledfb_pkg::OFS_GS_ADDR: begin
                rd_mux[ledfb_pkg::GSA_CH_LSB +: ledfb_pkg::CH_W] = s_q.gs_ch;
                rd_mux[ledfb_pkg::GSA_LINE_LSB +: ledfb_pkg::LINE_W] = s_q.gs_line;
            end
            ledfb_pkg::OFS_STATUS: begin
                rd_mux[ledfb_pkg::ST_BANK_BIT] = s_q.disp_bank;
                rd_mux[ledfb_pkg::ST_SHOWN_BIT] = s_q.shown;
                rd_mux[ledfb_pkg::ST_SEG513_BIT] = s_q.seg513;
                rd_mux[ledfb_pkg::ST_LINE_LSB +: ledfb_pkg::LINE_W] = s_q.line;
            end
            ledfb_pkg::OFS_OPEN_RED: begin
                rd_mux[15:0] = s_q.open_led_flag[15:0]; // R21
            end
            ledfb_pkg::OFS_OPEN_GREEN: begin
                rd_mux[15:0] = s_q.open_led_flag[31:16]; // R21
            end
            ledfb_pkg::OFS_OPEN_BLUE: begin
                rd_mux[15:0] = s_q.open_led_flag[47:32]; // R21
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        gs_word = '0;

        // input synchronisers
        s_d.grayscale_clock_s1 = grayscale_clock_i;
        s_d.grayscale_clock_s2 = s_q.grayscale_clock_s1;
        s_d.grayscale_clock_s3 = s_q.grayscale_clock_s2;
        s_d.sense_s1 = open_led_sense_i;
        s_d.sense_s2 = s_q.sense_s1;

        // one wait cycle, then answer
        s_d.ack = (avs_read_i | avs_write_i) & ~s_q.ack;
        if (avs_read_i && !s_q.ack) begin
            s_d.rdata = rd_mux;
        end

        // segment and scan line counting on the grayscale clock
        if (grayscale_clock_rise) begin
            if (seg_end) begin
                s_d.seg_cnt = '0;
                if (s_q.line == s_q.lines_m1) begin
                    s_d.line = '0;
                end else begin
                    s_d.line = 5'(s_q.line + 5'h01);
                end
            end else begin
                s_d.seg_cnt = 10'(s_q.seg_cnt + 10'h001);
            end
        end

        if (avs_write_i && s_q.ack) begin
            case (avs_address_i)
                ledfb_pkg::OFS_FC1: begin
                    s_d.fc1_stage = avs_writedata_i[29:0];
                end
                ledfb_pkg::OFS_FC2: begin
                    s_d.fc2_stage = avs_writedata_i[5:0];
                end
                ledfb_pkg::OFS_CMD: begin
                    if (avs_writedata_i[ledfb_pkg::CMD_WRFC_BIT]) begin
                        // codes drive the outputs directly: immediate effect
                        s_d.bc = s_q.fc1_stage[ledfb_pkg::FC1_BC_LSB +: ledfb_pkg::BC_W]; // R4
                        s_d.red_group_brightness = s_q.fc1_stage[ledfb_pkg::FC1_CCR_LSB +: ledfb_pkg::CC_W]; // R14
                        s_d.green_group_brightness = s_q.fc1_stage[ledfb_pkg::FC1_CCG_LSB +: ledfb_pkg::CC_W]; // R14
                        s_d.ccb = s_q.fc1_stage[ledfb_pkg::FC1_CCB_LSB +: ledfb_pkg::CC_W]; // R14
                        s_d.seg513 = s_q.fc2_stage[ledfb_pkg::FC2_SEG513_BIT]; // R4
                        s_d.lines_m1 =
                            s_q.fc2_stage[ledfb_pkg::FC2_LINES_LSB +: ledfb_pkg::LINE_W]; // R1
                    end
                    if (avs_writedata_i[ledfb_pkg::CMD_SYNC_BIT]) begin
                        s_d.disp_bank = ~s_q.disp_bank; // R10
                        s_d.shown = 1'b1; // R6
                        s_d.line = '0;
                        s_d.seg_cnt = '0;
                    end
                end
                ledfb_pkg::OFS_GS_ADDR: begin
                    s_d.gs_ch = avs_writedata_i[ledfb_pkg::GSA_CH_LSB +: ledfb_pkg::CH_W];
                    s_d.gs_line = avs_writedata_i[ledfb_pkg::GSA_LINE_LSB +: ledfb_pkg::LINE_W];
                end
                ledfb_pkg::OFS_GS_DATA: begin
                    // only the write bank, channel past 47 ignored
                    if (s_q.gs_ch < 6'(ledfb_pkg::CHANNELS)) begin
                        s_d.mem[~s_q.disp_bank][s_q.gs_line][s_q.gs_ch] =
                            avs_writedata_i[ledfb_pkg::GS_W-1:0]; // R5 R20
                        s_d.gs_ch = 6'(s_q.gs_ch + 6'h01);
                    end
                end
                default: begin
                end
            endcase
        end

        // pwm: upper grayscale bits against segment position
        for (int ch = 0; ch < ledfb_pkg::CHANNELS; ch++) begin
            gs_word = s_q.mem[s_q.disp_bank][s_q.line][ch]; // R1
            if (s_q.seg513) begin
                s_d.sink[ch] = s_q.shown & ({1'b0, gs_word[15:7]} > s_q.seg_cnt); // R2
            end else begin
                s_d.sink[ch] = s_q.shown & ({2'b00, gs_word[15:8]} > s_q.seg_cnt); // R2
            end
        end
        s_d.open_led_flag = s_q.sink & s_q.sense_s2; // R22
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0; // R3
            s_q.bc <= ledfb_pkg::BC_RST; // R13
            s_q.red_group_brightness <= ledfb_pkg::CC_RST; // R17
            s_q.green_group_brightness <= ledfb_pkg::CC_RST; // R17
            s_q.ccb <= ledfb_pkg::CC_RST; // R17
            s_q.fc1_stage[ledfb_pkg::FC1_BC_LSB +: ledfb_pkg::BC_W] <= ledfb_pkg::BC_RST;
            s_q.fc1_stage[ledfb_pkg::FC1_CCR_LSB +: ledfb_pkg::CC_W] <= ledfb_pkg::CC_RST;
            s_q.fc1_stage[ledfb_pkg::FC1_CCG_LSB +: ledfb_pkg::CC_W] <= ledfb_pkg::CC_RST;
            s_q.fc1_stage[ledfb_pkg::FC1_CCB_LSB +: ledfb_pkg::CC_W] <= ledfb_pkg::CC_RST;
            s_q.fc2_stage[ledfb_pkg::FC2_LINES_LSB +: ledfb_pkg::LINE_W] <=
                ledfb_pkg::LINES_M1_RST;
            s_q.lines_m1 <= ledfb_pkg::LINES_M1_RST;
            s_q.disp_bank <= ledfb_pkg::DISP_BANK_RST; // R23
            // sync chain starts at the pin's pull-up level: no false edge after reset
            s_q.grayscale_clock_s1 <= ledfb_pkg::GRAYSCALE_CLOCK_IDLE;
            s_q.grayscale_clock_s2 <= ledfb_pkg::GRAYSCALE_CLOCK_IDLE;
            s_q.grayscale_clock_s3 <= ledfb_pkg::GRAYSCALE_CLOCK_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.ack;
    assign avs_readdata_o = s_q.rdata;
    assign sink_output_channel_o = s_q.sink;
    assign open_led_flag_o = s_q.open_led_flag;
    assign global_brightness_code_o = s_q.bc; // R11 R12
    assign red_group_brightness_o = s_q.red_group_brightness; // R15 R16
    assign green_group_brightness_o = s_q.green_group_brightness; // R15 R16
    assign blue_group_brightness_o = s_q.ccb; // R15 R16
    assign current_gain_x10_o = ledfb_pkg::GAIN_X10[s_q.bc]; // R18
    assign scan_line_o = s_q.line;

endmodule

// [rtl/ledfb_pkg.sv]
// Purpose: constants for the LED frame bank and brightness control block
// Assumes: 32-bit Avalon-MM register bus, one word per register
// Notes: offsets are byte addresses
//
// Behaviour
// R1 - 48 outputs, 16-bit grayscale, 1-32 lines
// R2 - outputs off after power-on until displayed
// R3 - reset initialises counters and both control registers
// R4 - controller writes control only when non-default
// R5 - grayscale written into the non-displayed bank
// R6 - frame sync displays most recently written bank
// R7 - controller supplies 257 or 513 clock segments
// R8 - controller switches scan line between segments
// R9 - controller writes next frame during display
// R10 - frame sync swaps display and write banks
// R11 - 3-bit global brightness scales all outputs
// R12 - global brightness change acts immediately
// R13 - global brightness resets to 4h
// R14 - three 9-bit colour brightness codes kept
// R15 - colour code scales group 0 to 1FFh
// R16 - colour brightness change acts immediately
// R17 - colour brightness codes reset to 100h
// R18 - global code selects fixed gain table
// R19 - controller should prefer small global codes
// R20 - grayscale and brightness data written by port
// R21 - open-LED flag readable through port
// R22 - open flag set only while output on
// R23 - after reset write bank 0, display 1
package ledfb_pkg;
    localparam int CHANNELS = 48;
    localparam int LINES = 32;
    localparam int GS_W = 16;
    localparam int BC_W = 3;
    localparam int CC_W = 9;
    localparam int LINE_W = 5;
    localparam int CH_W = 6;
    localparam int SEG_W = 10;

    // register byte offsets
    localparam logic [7:0] OFS_FC1 = 8'h00;
    localparam logic [7:0] OFS_FC2 = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_GS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_GS_DATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_OPEN_RED = 8'h18;
    localparam logic [7:0] OFS_OPEN_GREEN = 8'h1C;
    localparam logic [7:0] OFS_OPEN_BLUE = 8'h20;

    // field positions
    localparam int FC1_BC_LSB = 0;
    localparam int FC1_CCR_LSB = 3;
    localparam int FC1_CCG_LSB = 12;
    localparam int FC1_CCB_LSB = 21;
    localparam int FC2_SEG513_BIT = 0;
    localparam int FC2_LINES_LSB = 1;
    localparam int CMD_WRFC_BIT = 0;
    localparam int CMD_SYNC_BIT = 1;
    localparam int GSA_CH_LSB = 0;
    localparam int GSA_LINE_LSB = 8;
    localparam int ST_BANK_BIT = 0;
    localparam int ST_SHOWN_BIT = 1;
    localparam int ST_SEG513_BIT = 2;
    localparam int ST_LINE_LSB = 8;

    // reset values
    localparam logic [BC_W-1:0] BC_RST = 3'h4;
    localparam logic [CC_W-1:0] CC_RST = 9'h100;
    localparam logic [LINE_W-1:0] LINES_M1_RST = 5'h1F;
    localparam logic DISP_BANK_RST = 1'b1;
    localparam logic GRAYSCALE_CLOCK_IDLE = 1'b1;

    // grayscale clock cycles per segment, minus one
    localparam logic [SEG_W-1:0] SEG_SHORT_LAST = 10'h100;
    localparam logic [SEG_W-1:0] SEG_LONG_LAST = 10'h200;

    // current gain times ten, index = global code
    localparam logic [7:0][10:0] GAIN_X10 = {11'h626, 11'h5A3, 11'h482, 11'h3FA,
                                             11'h338, 11'h255, 11'h193, 11'h0CC};
endpackage

// [tb/ledfb_ctrl_properties.sv]
// Purpose: port checker for ledfb_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound to every ledfb_ctrl instance
`timescale 1ns/100ps
module ledfb_ctrl_properties (
    // clock, reset, bus
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // display and codes
    input wire logic [47:0] sink_output_channel_o,
    input wire logic [47:0] open_led_flag_o,
    input wire logic [2:0] global_brightness_code_o,
    input wire logic [8:0] red_group_brightness_o,
    input wire logic [8:0] green_group_brightness_o,
    input wire logic [8:0] blue_group_brightness_o,
    input wire logic [10:0] current_gain_x10_o,
    input wire logic [4:0] scan_line_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    property p_gain; current_gain_x10_o == ledfb_pkg::GAIN_X10[global_brightness_code_o]; endproperty
    property p_off; $rose(resetn_i) |-> sink_output_channel_o == 48'h0 [*2]; endproperty
    property p_bc_rst; $rose(resetn_i) |-> global_brightness_code_o == 3'h4; endproperty
    property p_cc_rst;
        $rose(resetn_i) |-> red_group_brightness_o == 9'h100 && green_group_brightness_o == 9'h100
            && blue_group_brightness_o == 9'h100;
    endproperty
    property p_flag; (open_led_flag_o & ~$past(sink_output_channel_o)) == 48'h0; endproperty
    property p_code_cause; $changed(global_brightness_code_o) |-> $past(avs_write_i); endproperty
    property p_line;
        $changed(scan_line_o) |-> scan_line_o == $past(scan_line_o) + 5'h1 || scan_line_o == 5'h0;
    endproperty
    a_wait: assert property (p_wait) else $error("bus wait longer than one cycle");
    a_gain: assert property (p_gain) else $error("gain does not match code");
    a_off: assert property (p_off) else $error("sink on after reset");
    a_bc_rst: assert property (p_bc_rst) else $error("global code reset wrong");
    a_cc_rst: assert property (p_cc_rst) else $error("colour code reset wrong");
    a_flag: assert property (p_flag) else $error("open flag on an off output");
    a_code_cause: assert property (p_code_cause) else $error("code changed without write");
    a_line: assert property (p_line) else $error("scan line jumped");
    c_line: cover property ($changed(scan_line_o));
    c_sink: cover property (sink_output_channel_o != 48'h0);
    c_flag: cover property (open_led_flag_o != 48'h0);
endmodule
bind ledfb_ctrl ledfb_ctrl_properties u_ledfb_ctrl_properties (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .sink_output_channel_o(sink_output_channel_o),
    .open_led_flag_o(open_led_flag_o), .global_brightness_code_o(global_brightness_code_o),
    .red_group_brightness_o(red_group_brightness_o),
    .green_group_brightness_o(green_group_brightness_o),
    .blue_group_brightness_o(blue_group_brightness_o),
    .current_gain_x10_o(current_gain_x10_o), .scan_line_o(scan_line_o));

// [tb/ledfb_panel_model.sv]
// Purpose: display controller side, grayscale clock in segments
// Assumes: pin idles high (pull-up) while not running
// Notes: half period of 4 mclk, pause between segments for line switch
`timescale 1ns/100ps
module ledfb_panel_model #(
    parameter int SEG = 257
) (
    // clock and control
    input wire logic mclk_i,
    input wire logic run_i,
    // grayscale clock pin
    output logic grayscale_clock_o
);
    logic [1:0] ph = 2'h0;
    logic [9:0] n = 10'h000;
    logic [3:0] gap = 4'h0;
    initial grayscale_clock_o = 1'b1;
    always @(posedge mclk_i) begin
        if (!run_i) begin
            grayscale_clock_o <= 1'b1;
            ph <= 2'h0;
            n <= 10'h000;
            gap <= 4'h0;
        end else if (gap != 4'h0) begin
            gap <= gap - 4'h1;
        end else begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                grayscale_clock_o <= ~grayscale_clock_o;
                if (!grayscale_clock_o) begin
                    n <= (n == 10'(SEG - 1)) ? 10'h000 : n + 10'h1;
                    gap <= (n == 10'(SEG - 1)) ? 4'hF : 4'h0;
                end
            end
        end
    end
endmodule

// [tb/test_led_frame_bank_and_brightness_ctrl.sv]
// Purpose: self-checking bench for ledfb_ctrl
// Assumes: one wait cycle per bus access, bounded waits
// Notes: grayscale memory cleared by reset, only written channels checked
`timescale 1ns/100ps
module test_led_frame_bank_and_brightness_ctrl;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_r = 1'b0;
    logic wr_r = 1'b0;
    logic run = 1'b0;
    logic grayscale_clock;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic [31:0] q;
    logic wreq;
    logic [47:0] sense = 48'h0;
    logic [47:0] sink;
    logic [47:0] flag;
    logic [2:0] bc;
    logic [8:0] r, g, b;
    logic [10:0] gain;
    logic [4:0] line;
    logic [10:0] gains [0:7] = '{11'h0CC, 11'h193, 11'h255, 11'h338,
                                 11'h3FA, 11'h482, 11'h5A3, 11'h626};
    int num_errors = 0;
    int n_checks = 0;
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    ledfb_ctrl u_ledfb_ctrl (.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .grayscale_clock_i(grayscale_clock), .open_led_sense_i(sense),
        .sink_output_channel_o(sink), .open_led_flag_o(flag), .global_brightness_code_o(bc),
        .red_group_brightness_o(r), .green_group_brightness_o(g),
        .blue_group_brightness_o(b), .current_gain_x10_o(gain), .scan_line_o(line));
    ledfb_panel_model u_ledfb_panel_model (.mclk_i(mclk_i), .run_i(run),
        .grayscale_clock_o(grayscale_clock));
    task automatic close_out;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [47:0] e, input logic [47:0] v);
        n_checks++;
        if (v !== e) begin
            $display("BAD %s exp %h got %h", s, e, v);
            num_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge mclk_i);
        adr <= a;
        wd <= d;
        rd_r <= ~w;
        wr_r <= w;
        do begin
            @(posedge mclk_i);
            i++;
        end while (wreq !== 1'b0 && i < 20);
        q = rdata;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
        if (wreq !== 1'b0) begin
            chk("waitrequest", 48'h0, {47'h0, wreq});
            close_out();
        end
    endtask
    task automatic t_reset;
        chk("sinks", 48'h0, sink);
        chk("bc", 48'h4, {45'h0, bc});
        chk("cc", 48'h402_0100, {21'h0, b, g, r});
        chk("gain", 48'h3FA, {37'h0, gain});
        bus(1'b0, 8'h00, 32'h0);
        chk("fc1", 48'h2010_0804, {16'h0, q});
        bus(1'b0, 8'h04, 32'h0);
        chk("fc2", 48'h3E, {16'h0, q});
        bus(1'b0, 8'h14, 32'h0);
        chk("status", 48'h1, {16'h0, q});
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 48'h0, {16'h0, q});
    endtask
    task automatic t_codes;
        int k;
        bus(1'b1, 8'h00, 32'h1560_0FFF);
        bus(1'b0, 8'h00, 32'h0);
        chk("staged fc1", 48'h2010_0804, {16'h0, q});
        for (k = 0; k < 8; k++) begin
            bus(1'b1, 8'h00, {29'h02AC_01FF, 3'(k)});
            bus(1'b1, 8'h08, 32'h1);
            @(posedge mclk_i);
            chk("gain", {37'h0, gains[k]}, {37'h0, gain});
            chk("bc", {45'h0, 3'(k)}, {45'h0, bc});
        end
        chk("cc", {21'h0, 9'h0AB, 9'h000, 9'h1FF}, {21'h0, b, g, r});
        bus(1'b0, 8'h00, 32'h0);
        chk("fc1", 48'h1560_0FFF, {16'h0, q});
        bus(1'b1, 8'h00, 32'h1560_0FF8);
        bus(1'b1, 8'h08, 32'h1);
        @(posedge mclk_i);
        chk("bc low", 48'h0, {45'h0, bc});
    endtask
    task automatic t_banks;
        int i;
        bus(1'b1, 8'h04, 32'h2);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h10, 32'hFFFF);
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h08, 32'h2);
        sense <= {48{1'b1}};
        repeat (5) @(posedge mclk_i);
        chk("sink", 48'h1, {46'h0, sink[1:0]});
        chk("flag", 48'h1, {46'h0, flag[1:0]});
        bus(1'b0, 8'h14, 32'h0);
        chk("status", 48'h2, {16'h0, q});
        bus(1'b0, 8'h18, 32'h0);
        chk("open red", 48'h1, {46'h0, q[1:0]});
        run <= 1'b1;
        i = 0;
        while (line !== 5'h01 && i < 3000) begin
            @(posedge mclk_i);
            i++;
        end
        chk("line", 48'h1, {43'h0, line});
        if (i == 3000) close_out();
        run <= 1'b0;
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h10, 32'h8000);
        bus(1'b1, 8'h10, 32'h0080);
        bus(1'b1, 8'h08, 32'h2);
        repeat (3) @(posedge mclk_i);
        chk("sink swap", 48'h1, {46'h0, sink[1:0]});
        bus(1'b0, 8'h14, 32'h0);
        chk("status", 48'h3, {16'h0, q});
        bus(1'b1, 8'h04, 32'h3);
        bus(1'b1, 8'h08, 32'h1);
        repeat (3) @(posedge mclk_i);
        chk("sink 513", 48'h3, {46'h0, sink[1:0]});
        bus(1'b0, 8'h14, 32'h0);
        chk("status 513", 48'h7, {16'h0, q});
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_codes();
        t_banks();
        close_out();
    end
endmodule
